// ===== design/samc_top.sv
// menu control for a 12-bit sar converter behind an apb slave
// assumes the analog macro answers a start pulse with conv_valid
`timescale 1ns/10ps
module samc_top
(
    input  wire logic                           mclk,
    input  wire logic                           rst_n,
    input  wire logic                           psel,
    input  wire logic                           penable,
    input  wire logic                           pwrite,
    input  wire logic [7:0]                     paddr,
    input  wire logic [31:0]                    pwdata,
    output logic      [31:0]                    prdata,
    output logic                                pready,
    output logic                                pslverr,
    output logic                                conv_power_on,
    output logic                                bandgap_power_on,
    output logic      [3:0]                     input_select,
    output logic      [1:0]                     ref_pair_select,
    output logic                                conv_start,
    input  wire logic                           conv_valid,
    input  wire logic [samc_pkg::SAMC_RES_W-1:0] conv_result,
    output logic                                irq
);
    import samc_pkg::*;

    logic [31:0]           ctl;
    logic [31:0]           conf;
    logic                  menu_irq_enable;
    logic                  conv_done_flag;
    logic                  menu_flag;
    logic [SAMC_RES_W-1:0] result;
    logic [10:0]           cnt;
    samc_state_e           state;
    logic                  wr;
    logic                  rd;
    logic                  hit;
    logic                  menu_fin;
    logic                  conv_fin;
    logic                  valid_s1;
    logic                  valid_s2;
    logic [SAMC_RES_W-1:0] res_s1;
    logic [SAMC_RES_W-1:0] res_s2;

    function automatic logic [10:0] settle_len(input logic [3:0] code);
        logic [3:0] c;
        c = (code > SAMC_REF_SETTLE_COUNT_MAX) ? SAMC_REF_SETTLE_COUNT_MAX : code;
        settle_len = 11'h001 << c;
    endfunction

    assign wr      = psel && penable && pwrite;
    assign rd      = psel && !pwrite;
    assign pready  = 1'b1;
    assign hit     = (paddr == SAMC_OFS_CTL) || (paddr == SAMC_OFS_CONF)
                  || (paddr == SAMC_OFS_IEN) || (paddr == SAMC_OFS_ISR)
                  || (paddr == SAMC_OFS_DATA);
    assign pslverr = psel && penable && !hit;

    // analog result crosses from the macro, two stages first
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            valid_s1 <= 1'b0;
            valid_s2 <= 1'b0;
            res_s1   <= '0;
            res_s2   <= '0;
        end
        else
        begin
            valid_s1 <= conv_valid;
            valid_s2 <= valid_s1;
            res_s1   <= conv_result;
            res_s2   <= res_s1;
        end
    end

    assign conv_power_on    = ctl[SAMC_BIT_PWR];
    assign bandgap_power_on = ctl[SAMC_BIT_BG];
    assign input_select     = conf[SAMC_POS_INSEL +: 4];
    assign ref_pair_select  = conf[SAMC_POS_REFPAIR +: 2];

    // menu sequencer: settle, sample, convert
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            state    <= SAMC_IDLE;
            cnt      <= '0;
            menu_fin <= 1'b0;
            conv_fin <= 1'b0;
        end
        else
        begin
            menu_fin <= 1'b0;
            conv_fin <= 1'b0;
            case (state)
                SAMC_IDLE:
                begin
                    if (ctl[SAMC_BIT_START])
                    begin
                        if (conf[SAMC_BIT_SINGLE])
                        begin
                            state <= SAMC_SETTLE;
                            cnt   <= settle_len(
                                conf[SAMC_POS_SETTLE +: 4]) - 11'h001;
                        end
                        else
                        begin
                            state <= SAMC_DONE;
                        end
                    end
                end
                SAMC_SETTLE:
                begin
                    if (cnt == '0)
                    begin
                        state <= SAMC_SAMPLE;
                        cnt   <= {3'h0, conf[SAMC_POS_EXT +: 8]};
                    end
                    else
                    begin
                        cnt <= cnt - 11'h001;
                    end
                end
                SAMC_SAMPLE:
                begin
                    if (cnt == '0)
                    begin
                        state <= SAMC_CONV;
                    end
                    else
                    begin
                        cnt <= cnt - 11'h001;
                    end
                end
                SAMC_CONV:
                begin
                    if (valid_s2)
                    begin
                        state    <= SAMC_DONE;
                        conv_fin <= 1'b1;
                    end
                end
                SAMC_DONE:
                begin
                    state    <= SAMC_IDLE;
                    menu_fin <= 1'b1;
                end
                default:
                begin
                    state <= SAMC_IDLE;
                end
            endcase
        end
    end

    // start pulse is one clock plus the extension count
    assign conv_start = (state == SAMC_SAMPLE);

    // control register; menu_start cleared by hardware at the end
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            ctl <= SAMC_RST_VAL;
        end
        else
        begin
            if (wr && paddr == SAMC_OFS_CTL)
            begin
                ctl[SAMC_BIT_PWR] <= pwdata[SAMC_BIT_PWR];
                ctl[SAMC_BIT_BG]  <= pwdata[SAMC_BIT_BG];
                ctl[SAMC_BIT_START] <= pwdata[SAMC_BIT_START]
                                     | ctl[SAMC_BIT_START];
            end
            if (state == SAMC_DONE)
            begin
                ctl[SAMC_BIT_START] <= 1'b0;
            end
        end
    end

    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            conf            <= SAMC_RST_VAL;
            menu_irq_enable <= 1'b0;
        end
        else
        begin
            if (wr && paddr == SAMC_OFS_CONF)
            begin
                conf <= pwdata & SAMC_CONF_MASK;
            end
            if (wr && paddr == SAMC_OFS_IEN)
            begin
                menu_irq_enable <= pwdata[SAMC_BIT_MIEN];
            end
        end
    end

    // offset binary passes through untouched
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            result <= '0;
        end
        else if (state == SAMC_CONV && valid_s2)
        begin
            result <= res_s2;
        end
    end

    // set wins over a same-cycle write-one clear
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            conv_done_flag <= 1'b0;
            menu_flag      <= 1'b0;
        end
        else
        begin
            if (conv_fin)
            begin
                conv_done_flag <= 1'b1;
            end
            else if (wr && paddr == SAMC_OFS_ISR
                     && pwdata[SAMC_BIT_CFLAG])
            begin
                conv_done_flag <= 1'b0;
            end
            if (menu_fin)
            begin
                menu_flag <= 1'b1;
            end
            else if (wr && paddr == SAMC_OFS_ISR
                     && pwdata[SAMC_BIT_MFLAG])
            begin
                menu_flag <= 1'b0;
            end
        end
    end

    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            irq <= 1'b0;
        end
        else
        begin
            irq <= menu_flag && menu_irq_enable;
        end
    end

    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            prdata <= '0;
        end
        else
        begin
            prdata <= '0;
            if (rd && !penable)
            begin
                case (paddr)
                    SAMC_OFS_CTL:  prdata <= ctl;
                    SAMC_OFS_CONF: prdata <= conf;
                    SAMC_OFS_IEN:  prdata <= {31'h0, menu_irq_enable};
                    SAMC_OFS_ISR:
                    begin
                        prdata[SAMC_BIT_CFLAG] <= conv_done_flag;
                        prdata[SAMC_BIT_MFLAG] <= menu_flag;
                    end
                    SAMC_OFS_DATA: prdata <= {20'h0, result};
                    default:       prdata <= '0;
                endcase
            end
        end
    end
endmodule

// ===== inc/samc_pkg.sv
// constants, register map and types for the converter menu controller
// assumes apb access with 32-bit data and one converter clock domain
// Function
// - software sets menu_start; hardware clears it when all chosen tasks end
// - the converter power bit powers the converter off at 0 and on at 1
// - the bandgap power bit powers the bandgap off at 0 and on at 1
// - sample_extend_count adds that many clocks to the start pulse
// - an extension of zero gives a one-clock sample, each step adds a clock
// - settle for 2 to the power ref_settle_count clocks, 1024 above code 9
// - input_select 0 to 7 picks channels 0 to 7, 8 picks the reference
// - ref_pair_select 00 is ground and reference pin, 11 ground and supply
// - single_conv_enable puts a single-channel conversion in the menu
// - a finished conversion lands in bits 11:0, the upper bits read zero
// - menu_irq_enable lets the menu-complete flag request an interrupt
// - conv_done_flag sets when the conversion ends, writing one clears it
// - the menu-complete flag sets at menu end, writing one clears it
// - results are straight offset binary, one step is reference over 4096
package samc_pkg;
    localparam logic [7:0]  SAMC_OFS_CTL    = 8'h00;
    localparam logic [7:0]  SAMC_OFS_CONF   = 8'h04;
    localparam logic [7:0]  SAMC_OFS_IEN    = 8'h08;
    localparam logic [7:0]  SAMC_OFS_ISR    = 8'h0c;
    localparam logic [7:0]  SAMC_OFS_DATA   = 8'h28;
    localparam logic [31:0] SAMC_RST_VAL    = 32'h0000_0000;
    localparam int SAMC_BIT_PWR       = 0;
    localparam int SAMC_BIT_BG        = 1;
    localparam int SAMC_BIT_START     = 8;
    localparam int SAMC_BIT_SINGLE    = 2;
    localparam int SAMC_POS_REFPAIR   = 6;
    localparam int SAMC_POS_INSEL     = 12;
    localparam int SAMC_POS_SETTLE    = 16;
    localparam int SAMC_POS_EXT       = 24;
    localparam int SAMC_BIT_MFLAG     = 0;
    localparam int SAMC_BIT_CFLAG     = 10;
    localparam int SAMC_BIT_MIEN      = 0;
    localparam int SAMC_RES_W         = 12;
    localparam logic [3:0]  SAMC_REF_SETTLE_COUNT_MAX = 4'ha;
    localparam logic [31:0] SAMC_CONF_MASK  = 32'hff0f_f0c4;
    typedef enum logic [4:0]
    {
        SAMC_IDLE   = 5'b00001,
        SAMC_SETTLE = 5'b00010,
        SAMC_SAMPLE = 5'b00100,
        SAMC_CONV   = 5'b01000,
        SAMC_DONE   = 5'b10000
    } samc_state_e;
endpackage

// ===== dv/samc_props.sv
// assertions on the converter menu controller ports
// assumes the apb map of samc_pkg and one clock domain
`timescale 1ns/10ps
module samc_props
(
    input wire logic        mclk,
    input wire logic        rst_n,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pslverr,
    input wire logic        conv_power_on,
    input wire logic        bandgap_power_on,
    input wire logic [3:0]  input_select,
    input wire logic [1:0]  ref_pair_select,
    input wire logic        conv_start,
    input wire logic        irq
);
    import samc_pkg::*;
    logic       wr;
    logic [7:0] samp;
    logic [3:0] rc;
    int         hi;
    int         wt;
    int         st;
    assign wr = psel && penable && pwrite;
    assign st = (rc > SAMC_REF_SETTLE_COUNT_MAX) ? 1024 : (1 << rc);
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            samp <= 8'h00;
            rc   <= 4'h0;
        end
        else if (wr && paddr == SAMC_OFS_CONF)
        begin
            samp <= pwdata[31:24];
            rc   <= pwdata[19:16];
        end
    end
    // the idle cycle that sees menu_start adds one to the settle span
    always_ff @(posedge mclk)
    begin
        hi <= conv_start ? hi + 1 : 0;
        wt <= (wr && paddr == SAMC_OFS_CTL) ? 0 : wt + 1;
    end
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    a_slv_err: assert property (psel && penable |-> pslverr == !(paddr
        inside {8'h00, 8'h04, 8'h08, 8'h0c, 8'h28}))
        else $error("slave error flag wrong");
    a_start_width: assert property ($fell(conv_start) |->
        hi == samp + 1)
        else $error("start pulse length wrong");
    a_settle_time: assert property ($rose(conv_start) |->
        wt == st + 1)
        else $error("settle time wrong");
    a_sel_follow: assert property (wr && paddr == SAMC_OFS_CONF |=>
        input_select == $past(pwdata[15:12]))
        else $error("input select not updated");
    a_ref_follow: assert property (wr && paddr == SAMC_OFS_CONF |=>
        ref_pair_select == $past(pwdata[7:6]))
        else $error("reference pair not updated");
    a_pwr_follow: assert property (wr && paddr == SAMC_OFS_CTL |=>
        {conv_power_on, bandgap_power_on} == $past({pwdata[0], pwdata[1]}))
        else $error("power bits not updated");
    a_irq_mask: assert property (wr && paddr == SAMC_OFS_IEN &&
        !pwdata[0] |-> ##2 !irq)
        else $error("masked interrupt still high");
    a_data_upper: assert property (psel && penable && !pwrite &&
        paddr == SAMC_OFS_DATA |-> prdata[31:12] == 20'h00000)
        else $error("result upper bits not zero");
    c_pulse: cover property ($fell(conv_start));
    c_irq: cover property ($rose(irq));
    c_err: cover property (pslverr);
endmodule
bind samc_top samc_props i_props
(
    .mclk(mclk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pslverr(pslverr), .conv_power_on(conv_power_on),
    .bandgap_power_on(bandgap_power_on), .input_select(input_select),
    .ref_pair_select(ref_pair_select), .conv_start(conv_start), .irq(irq)
);

// ===== dv/samc_conv_model.sv
// behavioural model of the analog converter macro
// answers each start pulse after a short or a long delay
`timescale 1ns/10ps
module samc_conv_model
(
    input  wire logic        mclk,
    input  wire logic        rst_n,
    input  wire logic        conv_start,
    input  wire logic        slow,
    input  wire logic [11:0] res_in,
    output logic             conv_valid,
    output logic [11:0]      conv_result
);
    logic        st_d;
    logic [11:0] last = 12'h5a5;
    int          cnt;
    int          vcnt;
    // inverted last result outside valid, so stale data is never taken for a result
    assign conv_valid  = vcnt > 0;
    assign conv_result = conv_valid ? res_in : ~last;
    always @(posedge mclk)
    begin
        st_d <= conv_start;
        if (conv_valid)
            last <= res_in;
        if (vcnt > 0)
            vcnt <= vcnt - 1;
        if (!rst_n)
        begin
            cnt  <= 0;
            vcnt <= 0;
        end
        else if (st_d && !conv_start)
            cnt <= slow ? 6 : 1;
        else if (cnt == 1)
        begin
            cnt  <= 0;
            vcnt <= 2;
        end
        else if (cnt > 1)
            cnt <= cnt - 1;
    end
endmodule

// ===== dv/sar_adc_menu_control_test.sv
// self-checking bench for the converter menu controller
// assumes a zero-wait apb slave and the converter model at its far side
`timescale 1ns/10ps
`define CHK(g, e) chk(32'(g), 32'(e))
module sar_adc_menu_control_test;
    import samc_pkg::*;
    logic        mclk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0;
    logic        slow = 0, nac, pready, pslverr, cpo, bpo, cs, cv, irq;
    logic [7:0]  paddr = 0;
    logic [31:0] pwdata = 0, prdata, conf, dexp = 0;
    logic [3:0]  isel;
    logic [1:0]  rsel;
    logic [11:0] cr, res = 0;
    logic [31:0] expq[$];
    int          miscompares = 0, n_compared = 0, seed = 85, i, w;
    always #5 mclk = ~mclk;
    samc_top i_dut
    (
        .mclk(mclk), .rst_n(rst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .conv_power_on(cpo),
        .bandgap_power_on(bpo), .input_select(isel), .ref_pair_select(rsel),
        .conv_start(cs), .conv_valid(cv), .conv_result(cr), .irq(irq)
    );
    samc_conv_model i_conv
    (
        .mclk(mclk), .rst_n(rst_n), .conv_start(cs), .slow(slow),
        .res_in(res), .conv_valid(cv), .conv_result(cr)
    );
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_compared++;
        if (g !== e)
        begin
            miscompares++;
            $display("BAD at %0t got %h expected %h", $time, g, e);
        end
    endtask
    task automatic test_done;
        $display("compared %0d miscompares %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic xfer(input logic wr, input logic [7:0] a,
                        input logic [31:0] d);
        if (!wr)
            expq.push_back(d);
        @(posedge mclk);
        psel   <= 1;
        pwrite <= wr;
        paddr  <= a;
        pwdata <= wr ? d : 32'h0;
        @(posedge mclk);
        penable <= 1;
        do
            @(posedge mclk);
        while (pready !== 1'b1);
        psel    <= 0;
        penable <= 0;
    endtask
    task automatic look;
        repeat (2) @(posedge mclk);
        @(negedge mclk);
    endtask
    // reads judged in bus order against the noted values
    always @(posedge mclk)
        if (psel && penable && pready && !pwrite)
            `CHK(prdata, expq.pop_front());
    initial
    begin
        repeat (20000) @(posedge mclk);
        miscompares++;
        test_done;
    end
    initial
    begin
        repeat (8) @(posedge mclk);
        rst_n <= 1;
        for (i = 0; i < 16; i += 4)
            xfer(0, 8'(i), 0);
        xfer(0, 8'h10, 0);
        xfer(1, SAMC_OFS_DATA, 32'hfff);
        xfer(0, SAMC_OFS_DATA, 0);
        xfer(1, SAMC_OFS_IEN, 1);
        for (i = 0; i < 4; i++)
        begin
            // far-side inputs move only just after a rising edge
            @(posedge mclk);
            nac = i < 3;
            res <= 12'($random(seed));
            slow <= i[0];
            conf = 32'($random(seed)) & SAMC_CONF_MASK;
            conf[19:16] = (i == 2) ? 4'hc : 4'(i * 3);
            if (i == 0)
                conf[31:24] = 8'h00;
            conf[15:12] = (i == 1) ? 4'h8 : {1'b0, conf[14:12]};
            conf[7:6] = {2{i[0]}};
            conf[2] = nac;
            xfer(1, SAMC_OFS_CONF, conf | ~SAMC_CONF_MASK);
            xfer(0, SAMC_OFS_CONF, conf);
            @(negedge mclk);
            `CHK({isel, rsel}, {conf[15:12], conf[7:6]});
            xfer(1, SAMC_OFS_CTL, 32'h103);
            for (w = 0; w < 3000 && irq !== 1'b1; w++)
                @(posedge mclk);
            @(negedge mclk);
            `CHK({cpo, bpo, irq}, 3'h7);
            if (nac)
                dexp = 32'(res);
            xfer(0, SAMC_OFS_ISR, nac ? 32'h401 : 32'h1);
            xfer(0, SAMC_OFS_CTL, 32'h3);
            xfer(0, SAMC_OFS_DATA, dexp);
            xfer(1, SAMC_OFS_ISR, 32'h400);
            xfer(0, SAMC_OFS_ISR, 32'h1);
            xfer(1, SAMC_OFS_IEN, 0);
            look;
            `CHK(irq, 0);
            xfer(1, SAMC_OFS_IEN, 1);
            xfer(1, SAMC_OFS_ISR, 32'h1);
            look;
            `CHK(irq, 0);
        end
        xfer(1, SAMC_OFS_CTL, 32'h2);
        look;
        `CHK({cpo, bpo}, 2'h1);
        test_done;
    end
endmodule
